// ### csp_codec.sv
// codec model at the far side of the serial link
`default_nettype none
module csp_codec (
  input wire logic i_bclk,
  input wire logic i_fs,
  input wire logic i_fs_master,
  input wire logic i_dout,
  input wire logic [3:0] i_pat,
  output var logic o_din,
  output var logic o_fs,
  output var logic [3:0] o_word
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] cnt = 3'h0;
  logic [2:0] sh = 3'h0;
  logic [2:0] nx;
  assign nx = cnt + 3'h1;
  initial begin
    o_din = 1'b0;
    o_fs = 1'b0;
    o_word = 4'h0;
  end
  // data and slave sync on rise
  always @(posedge i_bclk) begin
    o_din <= i_pat[~nx[1:0]];
    o_fs <= (nx == 3'h7);
    cnt <= nx;
  end
  always @(negedge i_bclk) begin
    sh <= {sh[1:0], i_dout};
    if (cnt[1:0] == 2'h3) o_word <= {sh, i_dout};
    if (i_fs_master && i_fs) cnt <= 3'h0;
  end
endmodule
`default_nettype wire

// ### csp_converter_serial_port.sv
// framed serial port for audio codecs and converters, apb register slave
//
// Chosen here: the register offsets and the APB slave port.
`default_nettype none
// What this block does
// - bit clock pin drives out or takes in, chosen by bit_clock_direction
// - data out drives when sending, else zero or released per idle_output_mode
// - frame sync pin direction follows frame_sync_direction
// - received words of up to 16 bits stored left justified, unused low bits zero
// - short transmit words come from upper buffer bits, low bits ignored
// - one 16-bit shift register moves data in and out, msb first
// - 2-bit counter picks shadow words, 0 prefix receive, 1 prefix transmit
// - single address counter shared by transmit and receive
// - serial side uses shadow copies, software uses separate buffer words
// - clearing port_enable resets counters and stops the engine
// - while enabled the block owns direction and value of its pins
// - bit clock pin may run alone when its generator is on
// - word_size_field sets the period of the bit counter
// - word_size_field holds word length minus one, 1111 means 16
// - word size ignored in ac-link modes, slots fixed
// - frame_word_counter advances each time the bit counter wraps
// - frame length is word length times frame count plus one
// - ac-link ignores frame count, frame is 256 bit clocks
// - 2-bit mode picks multi-channel, i2s, ac-link 16 or ac-link 20
// - frame sync master when direction bit clear, slave when set
// - ac-link master sync high 16 bit clocks, low 240
// - slave multi-channel frame starts half a bit clock after sync seen high, on the next rise
module csp_converter_serial_port (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic o_pready,
  output logic [31:0] o_prdata,
  output logic o_pslverr,
  input wire logic i_serial_bit_clock,
  output logic o_serial_bit_clock,
  output logic o_serial_bit_clock_oe,
  input wire logic i_frame_sync_pin,
  output logic o_frame_sync_pin,
  output logic o_frame_sync_pin_oe,
  output logic o_serial_data_out,
  output logic o_serial_data_out_oe,
  input wire logic i_serial_data_in
);

  // ==========================================
  // state
  typedef struct packed {
    logic en;
    logic fsd;
    logic idle_mode;
    csp_pkg::csp_mode_e mode;
    logic [11:0] bcg;
    logic bckd;
    logic [3:0] ws;
    logic [3:0] fc;
    logic [11:0] div;
    logic gen_clk;
    logic ext_prev;
    logic active;
    logic pending;
    logic fs_prev;
    logic fs_out;
    logic dout;
    logic [4:0] bc;
    logic [3:0] wc;
    logic [7:0] pos;
    logic [1:0] addr;
    logic [15:0] sh;
    logic [7:0][15:0] shadow;
    logic [3:0][15:0] rx_cpu;
    logic [3:0][15:0] tx_cpu;
    logic [31:0] prdata;
  } csp_state_s;

  csp_state_s s_r;
  csp_state_s s_nxt;

  // ==========================================
  // functions
  function automatic logic addr_mapped(input logic [11:0] a);
    logic ok;
    ok = 1'b0;
    if (a[1:0] != 2'b00) begin
      ok = 1'b0;
    end else if (a == csp_pkg::CSP_OFS_CTRL_ONE || a == csp_pkg::CSP_OFS_CTRL_TWO) begin
      ok = 1'b1;
    end else if (a == csp_pkg::CSP_OFS_STATUS) begin
      ok = 1'b1;
    end else if (a >= csp_pkg::CSP_OFS_RX_BASE && a < csp_pkg::CSP_OFS_RX_BASE + csp_pkg::CSP_OFS_BUF_SPAN) begin
      ok = 1'b1;
    end else if (a >= csp_pkg::CSP_OFS_TX_BASE && a < csp_pkg::CSP_OFS_TX_BASE + csp_pkg::CSP_OFS_BUF_SPAN) begin
      ok = 1'b1;
    end
    return ok;
  endfunction

  function automatic logic [31:0] merge_strb(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] m;
    m = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        m[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return m;
  endfunction

  // word length decode
  function automatic logic [4:0] word_len(input csp_pkg::csp_mode_e m, input logic [3:0] ws,
                                          input logic [3:0] wc);
    logic [4:0] l;
    l = {1'b0, ws} + 5'h01;
    if (m == csp_pkg::CSP_MODE_AC16) begin
      l = csp_pkg::CSP_AC_TAG_BITS;
    end else if (m == csp_pkg::CSP_MODE_AC20) begin
      l = (wc == 4'h0) ? csp_pkg::CSP_AC_TAG_BITS : csp_pkg::CSP_AC20_SLOT_BITS;
    end
    return l;
  endfunction

  // left justify received bits
  function automatic logic [15:0] rx_justify(input logic [15:0] sh, input logic [4:0] wlen);
    logic [15:0] r;
    r = sh;
    if (wlen < csp_pkg::CSP_FULL_WORD) begin
      r = sh << (csp_pkg::CSP_FULL_WORD - wlen);
    end
    return r;
  endfunction

  // ==========================================
  // pin synchronisers
  logic [2:0] sync_q;
  logic ext_clk_s;
  logic fs_s;
  logic sdi_s;

  csp_sync2 #(
    .WIDTH(3)
  ) u_sync (
    .i_clk(i_ref_clk),
    .i_srst(i_srst),
    .i_d({i_serial_bit_clock, i_frame_sync_pin, i_serial_data_in}),
    .o_q(sync_q)
  );

  assign ext_clk_s = sync_q[2];
  assign fs_s = sync_q[1];
  assign sdi_s = sync_q[0];

  // ==========================================
  // decode
  logic gen_run;
  logic gen_tick;
  logic bclk_rise;
  logic bclk_fall;
  logic is_ac;
  logic [4:0] wlen;
  logic word_end;
  logic frame_end;
  logic [8:0] flen;
  logic apb_access;
  logic apb_setup;
  logic mapped;

  // generator runs on its own
  assign gen_run = (s_r.bcg != 12'h000);
  assign gen_tick = gen_run && (s_r.div == s_r.bcg);
  // edge source pick
  assign bclk_rise = s_r.bckd ? (ext_clk_s && !s_r.ext_prev) : (gen_tick && !s_r.gen_clk);
  assign bclk_fall = s_r.bckd ? (!ext_clk_s && s_r.ext_prev) : (gen_tick && s_r.gen_clk);
  assign is_ac = (s_r.mode == csp_pkg::CSP_MODE_AC16) || (s_r.mode == csp_pkg::CSP_MODE_AC20);
  assign wlen = word_len(s_r.mode, s_r.ws, s_r.wc);
  assign word_end = (s_r.bc == wlen - 5'h01);
  assign frame_end = is_ac ? (s_r.pos == csp_pkg::CSP_AC_LAST_POS) : (word_end && s_r.wc == s_r.fc);
  assign flen = 9'(wlen) * (9'(s_r.fc) + 9'h001);
  assign apb_access = i_psel && i_penable;
  assign apb_setup = i_psel && !i_penable;
  assign mapped = addr_mapped(i_paddr);

  // ==========================================
  // next state
  always_comb begin
    logic start;
    logic trig;
    logic [31:0] img;
    logic [31:0] wm;
    logic [1:0] bidx;
    start = 1'b0;
    trig = 1'b0;
    img = csp_pkg::CSP_RD_ZERO;
    wm = csp_pkg::CSP_RD_ZERO;
    bidx = i_paddr[3:2];
    s_nxt = s_r;

    if (gen_run) begin
      s_nxt.div = gen_tick ? 12'h000 : s_r.div + 12'h001;
      s_nxt.gen_clk = gen_tick ? !s_r.gen_clk : s_r.gen_clk;
    end else begin
      s_nxt.div = 12'h000;
      s_nxt.gen_clk = 1'b0;
    end
    s_nxt.ext_prev = ext_clk_s;

    if (!s_r.en) begin
      s_nxt.active = 1'b0;
      s_nxt.pending = 1'b0;
      s_nxt.fs_prev = 1'b0;
      s_nxt.fs_out = 1'b0;
      s_nxt.dout = 1'b0;
      s_nxt.bc = 5'h00;
      s_nxt.wc = 4'h0;
      s_nxt.pos = 8'h00;
      s_nxt.addr = 2'h0;
      s_nxt.sh = 16'h0000;
    end else begin
      if (bclk_rise) begin
        if (!s_r.active && (!s_r.fsd || s_r.pending)) begin
          start = 1'b1;
          s_nxt.active = 1'b1;
          s_nxt.pending = 1'b0;
        end
        if (s_r.active || start) begin
          if (s_r.bc == 5'h00) begin
            s_nxt.sh = s_r.shadow[{1'b1, s_r.addr}];
            s_nxt.dout = s_r.shadow[{1'b1, s_r.addr}][15];
          end else begin
            s_nxt.dout = (s_r.bc < csp_pkg::CSP_FULL_WORD) ? s_r.sh[15] : 1'b0;
          end
          case (s_r.mode)
            csp_pkg::CSP_MODE_MULTI: s_nxt.fs_out = (s_r.pos == 8'h00);
            csp_pkg::CSP_MODE_I2S: s_nxt.fs_out = ({s_r.pos, 1'b0} < flen);
            default: s_nxt.fs_out = (s_r.pos < csp_pkg::CSP_AC_SYNC_HIGH);
          endcase
        end
      end

      if (bclk_fall && s_r.active) begin
        s_nxt.sh = {s_r.sh[14:0], sdi_s};
        s_nxt.pos = frame_end ? 8'h00 : s_r.pos + 8'h01;
        if (word_end) begin
          s_nxt.shadow[{1'b0, s_r.addr}] = rx_justify({s_r.sh[14:0], sdi_s}, wlen);
          s_nxt.addr = s_r.addr + 2'h1;
          s_nxt.bc = 5'h00;
          s_nxt.wc = frame_end ? 4'h0 : s_r.wc + 4'h1;
          if (s_r.addr == 2'h3) begin
            for (int k = 0; k < 4; k++) begin
              s_nxt.rx_cpu[k] = s_nxt.shadow[k];
              s_nxt.shadow[4 + k] = s_r.tx_cpu[k];
            end
          end
        end else begin
          s_nxt.bc = s_r.bc + 5'h01;
        end
        if (frame_end && s_r.fsd) begin
          s_nxt.active = 1'b0;
        end
      end

      if (bclk_fall && s_r.fsd) begin
        trig = (s_r.mode == csp_pkg::CSP_MODE_I2S) ? (fs_s != s_r.fs_prev) : fs_s;
        s_nxt.fs_prev = fs_s;
        if (trig && (!s_r.active || frame_end)) begin
          s_nxt.pending = 1'b1;
        end
      end
    end

    // ==========================================
    // register read image
    if (i_paddr == csp_pkg::CSP_OFS_CTRL_ONE) begin
      img[csp_pkg::CSP_C1_EN_POS] = s_r.en;
      img[csp_pkg::CSP_C1_FSD_POS] = s_r.fsd;
      img[csp_pkg::CSP_C1_IDLE_POS] = s_r.idle_mode;
      img[csp_pkg::CSP_C1_MODE_POS +: csp_pkg::CSP_C1_MODE_W] = s_r.mode;
      img[csp_pkg::CSP_C1_BCG_POS +: csp_pkg::CSP_C1_BCG_W] = s_r.bcg;
    end else if (i_paddr == csp_pkg::CSP_OFS_CTRL_TWO) begin
      img[csp_pkg::CSP_C2_BCKD_POS] = s_r.bckd;
      img[csp_pkg::CSP_C2_WS_POS +: csp_pkg::CSP_C2_WS_W] = s_r.ws;
      img[csp_pkg::CSP_C2_FC_POS +: csp_pkg::CSP_C2_FC_W] = s_r.fc;
    end else if (i_paddr == csp_pkg::CSP_OFS_STATUS) begin
      img[csp_pkg::CSP_ST_ACTIVE_POS] = s_r.active;
      img[csp_pkg::CSP_ST_PEND_POS] = s_r.pending;
      img[csp_pkg::CSP_ST_ADDR_POS +: 2] = s_r.addr;
      img[csp_pkg::CSP_ST_WC_POS +: 4] = s_r.wc;
      img[csp_pkg::CSP_ST_BC_POS +: 5] = s_r.bc;
      img[csp_pkg::CSP_ST_POS_POS +: 8] = s_r.pos;
    end else if (mapped && i_paddr < csp_pkg::CSP_OFS_TX_BASE) begin
      img[15:0] = s_r.rx_cpu[bidx];
    end else if (mapped) begin
      img[15:0] = s_r.tx_cpu[bidx];
    end

    // ==========================================
    // apb read capture in setup phase
    if (apb_setup) begin
      s_nxt.prdata = img;
    end

    // apb write at access phase
    if (apb_access && i_pwrite && mapped) begin
      wm = merge_strb(img, i_pwdata, i_pstrb);
      if (i_paddr == csp_pkg::CSP_OFS_CTRL_ONE) begin
        s_nxt.en = wm[csp_pkg::CSP_C1_EN_POS];
        s_nxt.fsd = wm[csp_pkg::CSP_C1_FSD_POS];
        s_nxt.idle_mode = wm[csp_pkg::CSP_C1_IDLE_POS];
        s_nxt.mode = csp_pkg::csp_mode_e'(wm[csp_pkg::CSP_C1_MODE_POS +: csp_pkg::CSP_C1_MODE_W]);
        s_nxt.bcg = wm[csp_pkg::CSP_C1_BCG_POS +: csp_pkg::CSP_C1_BCG_W];
      end else if (i_paddr == csp_pkg::CSP_OFS_CTRL_TWO) begin
        s_nxt.bckd = wm[csp_pkg::CSP_C2_BCKD_POS];
        s_nxt.ws = wm[csp_pkg::CSP_C2_WS_POS +: csp_pkg::CSP_C2_WS_W];
        s_nxt.fc = wm[csp_pkg::CSP_C2_FC_POS +: csp_pkg::CSP_C2_FC_W];
      end else if (i_paddr >= csp_pkg::CSP_OFS_TX_BASE) begin
        s_nxt.tx_cpu[bidx] = wm[15:0];
      end
    end
  end

  // ==========================================
  // state register
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      s_r <= '0;
      s_r.mode <= csp_pkg::CSP_MODE_MULTI;
      s_r.bcg <= csp_pkg::CSP_RST_BCG;
      s_r.ws <= csp_pkg::CSP_RST_WS;
      s_r.fc <= csp_pkg::CSP_RST_FC;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================
  // bus outputs
  assign o_pready = 1'b1;
  assign o_prdata = s_r.prdata;
  assign o_pslverr = apb_access && !mapped;

  // ==========================================
  // pin outputs
  // bit clock pin
  assign o_serial_bit_clock = s_r.gen_clk;
  assign o_serial_bit_clock_oe = !s_r.bckd && (s_r.en || gen_run);
  assign o_frame_sync_pin = s_r.en && !s_r.fsd && s_r.fs_out;
  assign o_frame_sync_pin_oe = s_r.en && !s_r.fsd;
  assign o_serial_data_out = s_r.en && s_r.active && s_r.dout;
  assign o_serial_data_out_oe = s_r.en && (s_r.active || !s_r.idle_mode);

endmodule
`default_nettype wire

// ### csp_converter_serial_port_tb_top.sv
// testbench for the converter serial port
`default_nettype none
module csp_converter_serial_port_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [11:0] pa = 12'h000;
  logic [31:0] pwd = 32'h0000_0000;
  logic xclk = 1'b0;
  logic xrun = 1'b0;
  logic [3:0] pat = 4'ha;
  logic prdy, perr, bco, bcoe, fso, fsoe, sdo, sdoe, din, pfs;
  logic [31:0] prd;
  logic [3:0] word;
  int n_mismatch = 0;
  int n_checks = 0;
  int hi[4] = '{8, 32, 128, 128};
  int per[4] = '{64, 64, 2048, 2048};
  wire bclk = bcoe ? bco : xclk;
  wire fs = fsoe ? fso : pfs;
  wire dline = sdoe ? sdo : ~sdo;
  csp_converter_serial_port i_dut (.i_ref_clk(clk), .i_srst(srst), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pwd), .i_pstrb(4'hf), .o_pready(prdy), .o_prdata(prd),
    .o_pslverr(perr), .i_serial_bit_clock(bclk), .o_serial_bit_clock(bco), .o_serial_bit_clock_oe(bcoe),
    .i_frame_sync_pin(fs), .o_frame_sync_pin(fso), .o_frame_sync_pin_oe(fsoe), .o_serial_data_out(sdo),
    .o_serial_data_out_oe(sdoe), .i_serial_data_in(din));
  csp_codec i_codec (.i_bclk(bclk), .i_fs(fs), .i_fs_master(fsoe), .i_dout(dline), .i_pat(pat),
    .o_din(din), .o_fs(pfs), .o_word(word));
  initial forever #20 clk = ~clk;
  initial forever begin
    #160;
    if (xrun || xclk) xclk = ~xclk;
  end
  task end_of_test;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
    end while (prdy !== 1'b1);
    q = prd;
    e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0000_0000, q, e);
    chk("prdata", q, exp);
  endtask
  task lvl(input logic v, output int n);
    n = 0;
    while (fs !== v && n < 4000) begin
      @(posedge clk);
      n++;
    end
    if (n == 4000) n_mismatch++;
  endtask
  task meas(input int eh, input int ep);
    int n;
    int h;
    int l;
    lvl(1'b0, n);
    lvl(1'b1, n);
    lvl(1'b0, h);
    lvl(1'b1, l);
    chk("sync high", 32'(h), 32'(eh));
    chk("sync period", 32'(h + l), 32'(ep));
  endtask
  initial begin
    logic [31:0] q;
    logic e;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    chk("oe", {bcoe, fsoe, sdoe}, 32'h0000_0000);
    rd(csp_pkg::CSP_OFS_CTRL_ONE, 32'h0000_0000);
    rd(csp_pkg::CSP_OFS_CTRL_TWO, 32'h0000_00f0);
    apb(1'b0, 12'h0fc, 32'h0000_0000, q, e);
    chk("slverr", e, 32'h0000_0001);
    chk("bad read", q, 32'h0000_0000);
    for (int i = 0; i < 4; i++) begin
      wr(csp_pkg::CSP_OFS_TX_BASE + 12'(4 * i), 32'hffff_5fff);
      rd(csp_pkg::CSP_OFS_TX_BASE + 12'(4 * i), 32'h0000_5fff);
    end
    wr(csp_pkg::CSP_OFS_CTRL_TWO, 32'h0000_0130);
    wr(csp_pkg::CSP_OFS_CTRL_ONE, 32'h0003_0001);
    repeat (600) @(posedge clk);
    chk("codec word", word, 32'h0000_0005);
    chk("oe", {bcoe, fsoe, sdoe}, 32'h0000_0007);
    for (int i = 0; i < 4; i++) rd(csp_pkg::CSP_OFS_RX_BASE + 12'(4 * i), 32'h0000_a000);
    for (int m = 0; m < 4; m++) begin
      wr(csp_pkg::CSP_OFS_CTRL_ONE, 32'h0000_0000);
      wr(csp_pkg::CSP_OFS_CTRL_ONE, 32'h0003_0001 | (32'(m) << 4));
      meas(hi[m], per[m]);
    end
    wr(csp_pkg::CSP_OFS_CTRL_ONE, 32'h0000_0000);
    pat <= 4'h6;
    wr(csp_pkg::CSP_OFS_CTRL_TWO, 32'h0000_0131);
    wr(csp_pkg::CSP_OFS_CTRL_ONE, 32'h0000_0007);
    repeat (2) @(posedge clk);
    chk("oe", {bcoe, fsoe, sdoe}, 32'h0000_0000);
    wr(csp_pkg::CSP_OFS_CTRL_ONE, 32'h0000_0003);
    repeat (2) @(posedge clk);
    chk("oe", {bcoe, fsoe, sdoe}, 32'h0000_0001);
    xrun <= 1'b1;
    repeat (1000) @(posedge clk);
    chk("oe", {bcoe, fsoe, sdoe}, 32'h0000_0001);
    chk("codec word", word, 32'h0000_0005);
    for (int i = 0; i < 4; i++) rd(csp_pkg::CSP_OFS_RX_BASE + 12'(4 * i), 32'h0000_6000);
    xrun <= 1'b0;
    wr(csp_pkg::CSP_OFS_CTRL_TWO, 32'h0000_0130);
    wr(csp_pkg::CSP_OFS_CTRL_ONE, 32'h0003_0000);
    repeat (4) @(posedge clk);
    chk("oe", {bcoe, fsoe, sdoe}, 32'h0000_0004);
    wr(csp_pkg::CSP_OFS_CTRL_ONE, 32'h0000_0000);
    repeat (4) @(posedge clk);
    chk("oe", {bcoe, fsoe, sdoe}, 32'h0000_0000);
    end_of_test;
  end
  initial begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    end_of_test;
  end
endmodule
bind csp_converter_serial_port csp_monitor i_mon (.i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .o_pready(o_pready), .o_prdata(o_prdata),
  .o_pslverr(o_pslverr), .o_serial_bit_clock(o_serial_bit_clock), .o_serial_bit_clock_oe(o_serial_bit_clock_oe),
  .o_frame_sync_pin(o_frame_sync_pin), .o_frame_sync_pin_oe(o_frame_sync_pin_oe),
  .o_serial_data_out_oe(o_serial_data_out_oe));
`default_nettype wire

// ### csp_monitor.sv
// port checker for the converter serial port
`default_nettype none
module csp_monitor (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic o_pready,
  input wire logic [31:0] o_prdata,
  input wire logic o_pslverr,
  input wire logic o_serial_bit_clock,
  input wire logic o_serial_bit_clock_oe,
  input wire logic o_frame_sync_pin,
  input wire logic o_frame_sync_pin_oe,
  input wire logic o_serial_data_out_oe
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_srst);
  logic acc;
  logic map;
  logic stp;
  assign acc = i_psel && i_penable;
  assign stp = i_psel && !i_penable;
  assign map = (i_paddr[1:0] == 2'b00) && (i_paddr <= 12'h008 || (i_paddr >= 12'h010 && i_paddr <= 12'h02c));
  // ==========================================
  // register access
  ready_always_a: assert property (o_pready) else $error("pready low");
  err_unmapped_a: assert property (acc && !map |-> o_pslverr) else $error("no error on bad address");
  err_mapped_a: assert property (acc && map |-> !o_pslverr) else $error("error on good address");
  err_phase_a: assert property (o_pslverr |-> acc) else $error("error outside access");
  err_rdzero_a: assert property (acc && !i_pwrite && !map |-> o_prdata == 32'h0000_0000) else $error("bad read data");
  rd_hold_a: assert property (!$past(stp) |-> $stable(o_prdata)) else $error("read data moved");
  // ==========================================
  // pins
  reset_quiet_a: assert property ($fell(i_srst) |->
    !(o_serial_bit_clock_oe || o_frame_sync_pin_oe || o_serial_data_out_oe)) else $error("pin driven after reset");
  bclk_step_a: assert property (o_serial_bit_clock_oe && $changed(o_serial_bit_clock) |=>
    $stable(o_serial_bit_clock) || !o_serial_bit_clock_oe) else $error("bit clock too fast");
  sync_width_a: assert property ($rose(o_frame_sync_pin) && o_frame_sync_pin_oe |=>
    (o_frame_sync_pin || !o_frame_sync_pin_oe) [*3]) else $error("sync too short");
  cover property ($rose(o_frame_sync_pin) && o_frame_sync_pin_oe);
  cover property (acc && o_pslverr);
  cover property (o_serial_bit_clock_oe && !o_serial_data_out_oe);
endmodule
`default_nettype wire

// ### csp_pkg.sv
// shared constants and types for the converter serial port
`default_nettype none
package csp_pkg;

  // ==========================================
  // register byte offsets
  localparam logic [11:0] CSP_OFS_CTRL_ONE = 12'h000;
  localparam logic [11:0] CSP_OFS_CTRL_TWO = 12'h004;
  localparam logic [11:0] CSP_OFS_STATUS = 12'h008;
  localparam logic [11:0] CSP_OFS_RX_BASE = 12'h010;
  localparam logic [11:0] CSP_OFS_TX_BASE = 12'h020;
  localparam logic [11:0] CSP_OFS_BUF_SPAN = 12'h010;

  // ==========================================
  // port_control_one fields
  localparam int CSP_C1_EN_POS = 0;
  localparam int CSP_C1_FSD_POS = 1;
  localparam int CSP_C1_IDLE_POS = 2;
  localparam int CSP_C1_MODE_POS = 4;
  localparam int CSP_C1_MODE_W = 2;
  localparam int CSP_C1_BCG_POS = 16;
  localparam int CSP_C1_BCG_W = 12;

  // ==========================================
  // port_control_two fields
  localparam int CSP_C2_BCKD_POS = 0;
  localparam int CSP_C2_WS_POS = 4;
  localparam int CSP_C2_WS_W = 4;
  localparam int CSP_C2_FC_POS = 8;
  localparam int CSP_C2_FC_W = 4;

  // ==========================================
  // status fields
  localparam int CSP_ST_ACTIVE_POS = 0;
  localparam int CSP_ST_PEND_POS = 1;
  localparam int CSP_ST_ADDR_POS = 4;
  localparam int CSP_ST_WC_POS = 8;
  localparam int CSP_ST_BC_POS = 16;
  localparam int CSP_ST_POS_POS = 24;

  // ==========================================
  // reset values
  localparam logic [11:0] CSP_RST_BCG = 12'h000;
  localparam logic [3:0] CSP_RST_WS = 4'hf;
  localparam logic [3:0] CSP_RST_FC = 4'h0;
  localparam logic [31:0] CSP_RD_ZERO = 32'h0000_0000;

  // ==========================================
  // frame timing
  localparam logic [4:0] CSP_AC_TAG_BITS = 5'h10;
  localparam logic [4:0] CSP_AC20_SLOT_BITS = 5'h14;
  localparam logic [4:0] CSP_FULL_WORD = 5'h10;
  localparam logic [7:0] CSP_AC_LAST_POS = 8'hff;
  localparam logic [7:0] CSP_AC_SYNC_HIGH = 8'h10;

  // ==========================================
  // frame sync modes
  typedef enum logic [1:0] {
    CSP_MODE_MULTI,
    CSP_MODE_I2S,
    CSP_MODE_AC16,
    CSP_MODE_AC20
  } csp_mode_e;

endpackage
`default_nettype wire

// ### csp_sync2.sv
// two flip-flop synchroniser for pin inputs
`default_nettype none
module csp_sync2 #(
  parameter int WIDTH = 3
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic [WIDTH-1:0] i_d,
  output logic [WIDTH-1:0] o_q
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] hold_r;

  // ==========================================
  // two stages
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      meta_r <= '0;
      hold_r <= '0;
    end else begin
      meta_r <= i_d;
      hold_r <= meta_r;
    end
  end

  assign o_q = hold_r;

endmodule
`default_nettype wire
